// ---- wdt_pkg.sv ----
// constants, types and register map of the windowed watchdog timer
// assumes an ahb-lite bus master and a count clock sampled as a plain input

package wdt_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_RELOAD = 8'h04;
	localparam logic [7:0] OFS_FEED = 8'h08;
	localparam logic [7:0] OFS_VALUE = 8'h0C;
	localparam logic [7:0] OFS_WARN = 8'h14;
	localparam logic [7:0] OFS_WINDOW = 8'h18;
	localparam logic [7:0] OFS_CLKCFG = 8'h1C;

	// ************************************************************
	// fields and values
	// ************************************************************
	localparam int BIT_RUN = 0;
	localparam int BIT_RST = 1;
	localparam int BIT_TOF = 2;
	localparam int BIT_WINT = 3;
	localparam int BIT_PROT = 4;
	localparam int BIT_OSCPD = 2;
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] RELOAD_MIN = 24'h00_00FF;
	localparam logic [CNT_W-1:0] WINDOW_RST = 24'hFF_FFFF;
	localparam logic [CNT_W-1:0] WARN_RST = 24'h00_0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
	localparam logic [7:0] FEED_FIRST = 8'hAA;
	localparam logic [7:0] FEED_SECOND = 8'h55;
	localparam logic [1:0] PRESC_LAST = 2'h3;
	localparam logic [1:0] SYNC_LAST = 2'h2;
	localparam logic [1:0] SEL_WDOSC = 2'h1;
	localparam logic [1:0] SEL_RST = 2'h0;

	typedef enum logic {
		FEED_IDLE = 1'b0,
		FEED_HALF = 1'b1
	} feed_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ahb_dp_s;

	typedef struct packed {
		logic run;
		logic rst_en;
		logic protect;
	} mode_s;

	typedef struct packed {
		feed_e feed_st;
		mode_s act;
		mode_s shadow;
		mode_s staged;
		logic tof;
		logic wint;
		logic [CNT_W-1:0] reload_sh;
		logic [CNT_W-1:0] reload_act;
		logic sync_busy;
		logic [1:0] sync_cnt;
		logic [1:0] presc;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] cap;
		logic [CNT_W-1:0] snap;
		logic [CNT_W-1:0] warn;
		logic [CNT_W-1:0] win;
		logic [1:0] clk_sel;
		logic osc_pd;
		logic cc_prev;
		ahb_dp_s dp;
		logic [31:0] rdata;
		logic chip_rst;
	} state_s;

endpackage : wdt_pkg

// ---- windowed_watchdog_timer.sv ----
// windowed watchdog timer with an ahb-lite register slave
// assumes COUNT_CLK is synchronous to CLK and slower than CLK/2

`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CE,
	input wire logic COUNT_CLK,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic CHIP_RESET_REQ,
	output logic WARN_IRQ,
	output logic [1:0] CLK_SEL,
	output logic OSC_PD
);

	// ************************************************************
	// state
	// ************************************************************
	wdt_pkg::state_s s;
	wdt_pkg::state_s n;
	logic tick;
	logic wr;
	logic feed_ok;
	logic feed_err;
	logic early;
	logic tout;
	logic prot_err;
	logic ev;
	logic [7:0] fb;
	logic [wdt_pkg::CNT_W-1:0] load_val;
	logic [wdt_pkg::CNT_W-1:0] dec;

	localparam wdt_pkg::state_s RST_S = '{
		feed_st: wdt_pkg::FEED_IDLE,
		act: '0,
		shadow: '0,
		staged: '0,
		tof: 1'b0,
		wint: 1'b0,
		reload_sh: wdt_pkg::RELOAD_MIN,
		reload_act: wdt_pkg::RELOAD_MIN,
		sync_busy: 1'b0,
		sync_cnt: '0,
		presc: '0,
		cnt: wdt_pkg::RELOAD_MIN,
		cap: wdt_pkg::RELOAD_MIN,
		snap: wdt_pkg::RELOAD_MIN,
		warn: wdt_pkg::WARN_RST,
		win: wdt_pkg::WINDOW_RST,
		clk_sel: wdt_pkg::SEL_RST,
		osc_pd: 1'b0,
		cc_prev: 1'b0,
		dp: '0,
		rdata: '0,
		chip_rst: 1'b0
	};

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		n = s;
		n.chip_rst = 1'b0;
		// count clock is sampled, so its edge is one bus cycle wide
		tick = COUNT_CLK & ~s.cc_prev;
		n.cc_prev = COUNT_CLK;
		wr = s.dp.valid & s.dp.write;
		fb = HWDATA[7:0];
		feed_ok = 1'b0;
		feed_err = 1'b0;
		early = 1'b0;
		tout = 1'b0;
		prot_err = 1'b0;
		dec = s.cnt - wdt_pkg::CNT_ONE;
		if (s.reload_act < wdt_pkg::RELOAD_MIN) begin
			load_val = wdt_pkg::RELOAD_MIN;
		end else begin
			load_val = s.reload_act;
		end

		// mode and reload reach the count side after three ticks
		if (s.sync_busy && tick) begin
			n.sync_cnt = s.sync_cnt + 2'h1;
			if (s.sync_cnt == wdt_pkg::SYNC_LAST) begin
				n.sync_busy = 1'b0;
				n.reload_act = s.reload_sh;
				n.staged = s.shadow;
			end
		end

		// bus writes, clears come before hardware sets
		if (wr) begin
			case (s.dp.addr)
				wdt_pkg::OFS_MODE: begin
					n.shadow.run = s.shadow.run | HWDATA[wdt_pkg::BIT_RUN];
					n.shadow.rst_en = s.shadow.rst_en | HWDATA[wdt_pkg::BIT_RST];
					n.shadow.protect = s.shadow.protect | HWDATA[wdt_pkg::BIT_PROT];
					if (HWDATA[wdt_pkg::BIT_TOF]) begin
						n.tof = 1'b0;
					end
					if (HWDATA[wdt_pkg::BIT_WINT]) begin
						n.wint = 1'b0;
					end
					n.sync_busy = 1'b1;
					n.sync_cnt = '0;
				end
				wdt_pkg::OFS_RELOAD: begin
					if (!s.act.protect || (s.cnt < s.warn)) begin
						n.reload_sh = HWDATA[wdt_pkg::CNT_W-1:0];
						n.sync_busy = 1'b1;
						n.sync_cnt = '0;
					end else begin
						prot_err = 1'b1;
					end
				end
				wdt_pkg::OFS_FEED: begin
					case (s.feed_st)
						wdt_pkg::FEED_IDLE: begin
							if (fb == wdt_pkg::FEED_FIRST) begin
								n.feed_st = wdt_pkg::FEED_HALF;
							end else begin
								feed_err = 1'b1;
							end
						end
						wdt_pkg::FEED_HALF: begin
							n.feed_st = wdt_pkg::FEED_IDLE;
							if (fb == wdt_pkg::FEED_SECOND) begin
								feed_ok = 1'b1;
							end else begin
								feed_err = 1'b1;
							end
						end
						default: begin
							n.feed_st = wdt_pkg::FEED_IDLE;
						end
					endcase
				end
				wdt_pkg::OFS_WARN: begin
					n.warn = HWDATA[wdt_pkg::CNT_W-1:0];
				end
				wdt_pkg::OFS_WINDOW: begin
					n.win = HWDATA[wdt_pkg::CNT_W-1:0];
				end
				wdt_pkg::OFS_CLKCFG: begin
					if (!s.act.run) begin
						n.clk_sel = HWDATA[1:0];
					end
					n.osc_pd = HWDATA[wdt_pkg::BIT_OSCPD];
				end
				default: begin
				end
			endcase
		end

		// a valid feed applies staged mode and reloads
		if (feed_ok) begin
			if (s.act.run && (s.cnt > s.win)) begin
				early = 1'b1;
			end else if (s.act.run || s.staged.run) begin
				n.act.run = 1'b1;
				n.act.rst_en = s.act.rst_en | s.staged.rst_en;
				n.act.protect = s.act.protect | s.staged.protect;
				n.cnt = load_val;
				n.presc = '0;
			end
		end

		// prescaler by four, then the down-counter
		if (s.act.run && tick && !feed_ok) begin
			n.presc = s.presc + 2'h1;
			if (s.presc == wdt_pkg::PRESC_LAST && s.cnt != wdt_pkg::CNT_ZERO) begin
				n.cnt = dec;
				if (dec == s.warn) begin
					n.wint = 1'b1;
				end
				if (dec == wdt_pkg::CNT_ZERO) begin
					tout = 1'b1;
				end
			end
		end
		if (tick) begin
			n.cap = n.cnt;
		end
		n.snap = s.cap;

		// events only count while the watchdog runs
		ev = s.act.run & (tout | early | feed_err | prot_err);
		if (ev) begin
			n.tof = 1'b1;
			if (s.act.rst_en) begin
				// flag kept, mode, feed state, count and prescaler back to stopped
				n.chip_rst = 1'b1;
				n.act = '0;
				n.shadow = '0;
				n.staged = '0;
				n.feed_st = wdt_pkg::FEED_IDLE;
				n.cnt = wdt_pkg::RELOAD_MIN;
				n.presc = '0;
			end
		end

		// address phase, read data captured for the data phase
		n.dp.valid = HSEL & HREADY & HTRANS[1];
		n.dp.write = HWRITE;
		n.dp.addr = HADDR[7:0];
		if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
			case (HADDR[7:0])
				wdt_pkg::OFS_MODE: begin
					n.rdata = {27'h000_0000, s.act.protect, s.wint, s.tof,
						s.act.rst_en, s.act.run};
				end
				wdt_pkg::OFS_RELOAD: begin
					n.rdata = {8'h00, s.reload_sh};
				end
				wdt_pkg::OFS_VALUE: begin
					n.rdata = {8'h00, s.snap};
				end
				wdt_pkg::OFS_WARN: begin
					n.rdata = {8'h00, s.warn};
				end
				wdt_pkg::OFS_WINDOW: begin
					n.rdata = {8'h00, s.win};
				end
				wdt_pkg::OFS_CLKCFG: begin
					n.rdata = {29'h0000_0000, s.osc_pd, s.clk_sel};
				end
				default: begin
					n.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s <= RST_S;
		end else if (CE) begin
			s <= n;
		end
	end

	assign HRDATA = s.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign CHIP_RESET_REQ = s.chip_rst;
	assign WARN_IRQ = s.wint;
	assign CLK_SEL = s.clk_sel;
	// a running watchdog must keep its own oscillator alive
	assign OSC_PD = s.osc_pd & ~(s.act.run & (s.clk_sel == wdt_pkg::SEL_WDOSC));

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	AST_DEC_ON_WRAP: assert property (
		(s.cnt == $past(s.cnt) - wdt_pkg::CNT_ONE) && $past(CE)
		|-> $past(s.presc) == wdt_pkg::PRESC_LAST && $past(tick))
		else $error("counter moved off prescaler wrap");
	AST_MIN_LOAD: assert property (
		CE && feed_ok && !ev |=> s.cnt >= wdt_pkg::RELOAD_MIN)
		else $error("load below minimum");
	AST_RUN_STICKY: assert property (
		s.act.run && !(CE && ev && s.act.rst_en) |=> s.act.run)
		else $error("run bit cleared");
	AST_TOF_HOLD: assert property (
		s.tof && !(CE && wr && s.dp.addr == wdt_pkg::OFS_MODE) |=> s.tof)
		else $error("timeout flag lost");
	AST_RESET_REQ: assert property (
		CE && ev && s.act.rst_en |=> CHIP_RESET_REQ ##1 !CHIP_RESET_REQ)
		else $error("no chip reset pulse");
	AST_NO_RESET: assert property (
		$rose(CHIP_RESET_REQ) |-> $past(s.act.rst_en) && $past(ev))
		else $error("reset without enable");
	AST_SEL_LOCK: assert property (
		s.act.run |=> $stable(CLK_SEL))
		else $error("clock select changed while running");
	AST_OSC_ON: assert property (
		s.act.run && CLK_SEL == wdt_pkg::SEL_WDOSC |-> !OSC_PD)
		else $error("oscillator powered down");
	AST_EARLY: assert property (
		CE && feed_ok && s.act.run && s.cnt > s.win |=> s.tof)
		else $error("early feed not flagged");
	AST_FEED_ERR: assert property (
		CE && feed_err && s.act.run |=> s.tof)
		else $error("feed error not flagged");
	AST_SYNC: assert property (
		s.reload_act != $past(s.reload_act)
		|-> $past(s.sync_cnt) == wdt_pkg::SYNC_LAST && $past(tick))
		else $error("reload took effect early");
	AST_WARN: assert property (
		CE && tick && s.act.run && s.presc == wdt_pkg::PRESC_LAST
		&& s.cnt != wdt_pkg::CNT_ZERO && dec == s.warn && !feed_ok
		|=> s.wint)
		else $error("warning not raised");
	AST_PROT_DROP: assert property (
		CE && wr && s.dp.addr == wdt_pkg::OFS_RELOAD && s.act.protect
		&& !(s.cnt < s.warn) |=> s.reload_sh == $past(s.reload_sh))
		else $error("protected reload accepted");
	AST_FEED_LOAD: assert property (
		CE && feed_ok && !ev && (s.act.run || s.staged.run)
		|=> s.act.run && s.cnt >= wdt_pkg::RELOAD_MIN)
		else $error("valid feed did not start the counter");
	AST_TIMEOUT: assert property (
		CE && tout && s.act.run |=> s.tof)
		else $error("timeout not flagged");
	AST_WINT_HOLD: assert property (
		s.wint && !(CE && wr && s.dp.addr == wdt_pkg::OFS_MODE) |=> s.wint)
		else $error("warning flag lost");
	AST_RST_EN_ONLY: assert property (
		s.act.rst_en && !(CE && ev) |=> s.act.rst_en)
		else $error("reset enable cleared");

	// a frozen block must not even advance its sampler of the count clock
	AST_FREEZE: assert property (
		!CE |=> s == $past(s))
		else $error("state moved while clock enable low");

	COV_START: cover property ($rose(s.act.run));
	COV_FEED_ERR: cover property (feed_err && s.act.run);
	COV_TIMEOUT: cover property (tout ##1 CHIP_RESET_REQ);
	COV_WARN: cover property ($rose(s.wint));
	COV_EARLY: cover property (early);

endmodule : windowed_watchdog_timer

`default_nettype wire

// ---- windowed_watchdog_timer_bench.sv ----
// self-checking bench for the windowed watchdog timer
// assumes a zero-wait ahb-lite slave and a count clock at CLK/4
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer_bench;
	// ****************************************************
	// signals
	// ****************************************************
	logic CLK;
	logic ARST_N;
	logic count_clk;
	logic [1:0] div;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic CHIP_RESET_REQ;
	logic WARN_IRQ;
	logic [1:0] CLK_SEL;
	logic OSC_PD;
	int fail_count;
	int checked;
	int pulses;
	int n;
	logic [31:0] v;
	logic [31:0] lo;
	logic ce;

	windowed_watchdog_timer dut (
		.CLK(CLK), .ARST_N(ARST_N), .CE(ce), .COUNT_CLK(count_clk),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.CHIP_RESET_REQ(CHIP_RESET_REQ), .WARN_IRQ(WARN_IRQ),
		.CLK_SEL(CLK_SEL), .OSC_PD(OSC_PD)
	);

	// ****************************************************
	// clock, count clock and reset pulse monitor
	// ****************************************************
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	// two cycles per level keeps each count tick visible to the sampler
	always @(posedge CLK) begin
		div <= div + 2'h1;
		count_clk <= div[1];
		if (CHIP_RESET_REQ === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	// ****************************************************
	// tasks
	// ****************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// entered just after a rising edge; returns at the data-phase edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		v = HRDATA;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, a, 32'h0000_0000);
		check(v & m, e);
	endtask : rc

	task automatic feed();
		wr(wdt_pkg::OFS_FEED, 32'h0000_00AA);
		wr(wdt_pkg::OFS_FEED, 32'h0000_0055);
	endtask : feed

	task automatic in_range(input logic [31:0] lo, input logic [31:0] hi);
		xfer(1'b0, wdt_pkg::OFS_VALUE, 32'h0000_0000);
		check({31'h0000_0000, (v >= lo) && (v <= hi)}, 32'h0000_0001);
	endtask : in_range

	task automatic conclude();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// longest waits together span one count-down of about 4100 cycles
	initial begin
		repeat (20000) @(posedge CLK);
		fail_count++;
		conclude();
	end

	// ****************************************************
	// tests
	// ****************************************************
	initial begin
		ARST_N = 1'b0;
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		ce = 1'b1;
		{div, count_clk, fail_count, checked, pulses} = '0;
		repeat (10) @(posedge CLK);
		ARST_N <= 1'b1;
		@(posedge CLK);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0000, 32'hFFFF_FFFF);
		rc(wdt_pkg::OFS_RELOAD, 32'h0000_00FF, 32'hFFFF_FFFF);
		rc(wdt_pkg::OFS_VALUE, 32'h0000_00FF, 32'hFFFF_FFFF);
		rc(wdt_pkg::OFS_WARN, 32'h0000_0000, 32'hFFFF_FFFF);
		rc(wdt_pkg::OFS_WINDOW, 32'h00FF_FFFF, 32'hFFFF_FFFF);
		rc(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
		check({30'h0000_0000, HRESP, HREADYOUT}, 32'h0000_0001);
		// reload below the floor, warning, run, oscillator source
		wr(wdt_pkg::OFS_RELOAD, 32'h0000_0010);
		wr(wdt_pkg::OFS_WARN, 32'h0000_0080);
		wr(wdt_pkg::OFS_MODE, 32'h0000_0001);
		wr(wdt_pkg::OFS_CLKCFG, 32'h0000_0005);
		@(posedge CLK);
		check({31'h0000_0000, OSC_PD}, 32'h0000_0001);
		repeat (20) @(posedge CLK);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0000, 32'h0000_0013);
		feed();
		repeat (4) @(posedge CLK);
		check({31'h0000_0000, OSC_PD}, 32'h0000_0000);
		wr(wdt_pkg::OFS_CLKCFG, 32'h0000_0000);
		rc(wdt_pkg::OFS_CLKCFG, 32'h0000_0001, 32'h0000_0003);
		check({30'h0000_0000, CLK_SEL}, 32'h0000_0001);
		wr(wdt_pkg::OFS_MODE, 32'h0000_0000);
		repeat (20) @(posedge CLK);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0001, 32'h0000_0013);
		in_range(32'h0000_00F0, 32'h0000_00FF);
		// warning flag at the compare value, sticky until cleared
		for (n = 0; n < 4000 && WARN_IRQ !== 1'b1; n++) @(posedge CLK);
		check({31'h0000_0000, WARN_IRQ}, 32'h0000_0001);
		in_range(32'h0000_007F, 32'h0000_0081);
		repeat (40) @(posedge CLK);
		check({31'h0000_0000, WARN_IRQ}, 32'h0000_0001);
		wr(wdt_pkg::OFS_MODE, 32'h0000_0008);
		repeat (2) @(posedge CLK);
		check({31'h0000_0000, WARN_IRQ}, 32'h0000_0000);
		// timeout without reset enable only sets the flag
		for (n = 0; n < 3000; n++) begin
			xfer(1'b0, wdt_pkg::OFS_VALUE, 32'h0000_0000);
			if (v == 32'h0000_0000) break;
		end
		check(v, 32'h0000_0000);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0005, 32'h0000_0017);
		check(pulses, 32'h0000_0000);
		wr(wdt_pkg::OFS_RELOAD, 32'h0000_0123);
		repeat (20) @(posedge CLK);
		feed();
		repeat (10) @(posedge CLK);
		in_range(32'h0000_0120, 32'h0000_0123);
		// clock enable low: the count must not move while frozen
		xfer(1'b0, wdt_pkg::OFS_VALUE, 32'h0000_0000);
		lo = v;
		ce <= 1'b0;
		repeat (64) @(posedge CLK);
		ce <= 1'b1;
		in_range(lo - 32'h0000_0001, lo);
		// early feed before the window opens
		wr(wdt_pkg::OFS_MODE, 32'h0000_0004);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0001, 32'h0000_0007);
		wr(wdt_pkg::OFS_WINDOW, 32'h0000_0040);
		feed();
		rc(wdt_pkg::OFS_MODE, 32'h0000_0005, 32'h0000_0007);
		wr(wdt_pkg::OFS_WINDOW, 32'h00FF_FFFF);
		wr(wdt_pkg::OFS_MODE, 32'h0000_0004);
		// broken feed pair, first as status, then as chip reset
		wr(wdt_pkg::OFS_FEED, 32'h0000_0012);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0005, 32'h0000_0007);
		wr(wdt_pkg::OFS_MODE, 32'h0000_0006);
		repeat (20) @(posedge CLK);
		feed();
		check(pulses, 32'h0000_0000);
		wr(wdt_pkg::OFS_FEED, 32'h0000_0012);
		repeat (4) @(posedge CLK);
		check(pulses, 32'h0000_0001);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0004, 32'h0000_0017);
		repeat (10) @(posedge CLK);
		rc(wdt_pkg::OFS_VALUE, 32'h0000_00FF, 32'hFFFF_FFFF);
		// protected reload refused above the warning compare
		wr(wdt_pkg::OFS_MODE, 32'h0000_0015);
		repeat (20) @(posedge CLK);
		feed();
		wr(wdt_pkg::OFS_RELOAD, 32'h0000_0200);
		rc(wdt_pkg::OFS_RELOAD, 32'h0000_0123, 32'hFFFF_FFFF);
		rc(wdt_pkg::OFS_MODE, 32'h0000_0015, 32'h0000_0017);
		conclude();
	end
endmodule : windowed_watchdog_timer_bench

`default_nettype wire
